//--- logic/fpd_pkg.sv
package fpd_pkg;

  // ==========================================
  // Register indices
  localparam logic [3:0] IDX_FAULT = 4'h0;
  localparam logic [3:0] IDX_PROG = 4'h1;
  localparam logic [3:0] IDX_MAKER1 = 4'h2;
  localparam logic [3:0] IDX_MAKER2 = 4'h3;
  localparam logic [3:0] IDX_USER1 = 4'h4;
  localparam logic [3:0] IDX_USER2 = 4'h5;
  localparam logic [3:0] IDX_PHASE = 4'h6;
  localparam logic [3:0] IDX_SCALE1 = 4'h7;
  localparam logic [3:0] IDX_SCALE2 = 4'h8;
  localparam logic [3:0] IDX_COEFF1 = 4'h9;
  localparam logic [3:0] IDX_COEFF2 = 4'ha;
  localparam logic [3:0] IDX_COEFF3 = 4'hb;
  localparam logic [3:0] IDX_SEL1 = 4'hc;
  localparam logic [3:0] IDX_SEL2 = 4'hd;
  localparam logic [3:0] IDX_DEADBAND = 4'he;

  // ==========================================
  // Field layouts and reset values
  localparam logic [15:0] FAULT_USED_MASK = 16'h03fb;
  localparam logic [15:0] PROG_HW_MASK = 16'h0700;
  localparam logic [15:0] PROG_SW_MASK = 16'h003f;
  localparam int unsigned FB_CLAMP_HI = 9;
  localparam int unsigned FB_CLAMP_LO = 8;
  localparam int unsigned FB_CLIP1 = 7;
  localparam int unsigned FB_CLIP2 = 6;
  localparam int unsigned FB_DSP = 5;
  localparam int unsigned FB_EEPROM = 4;
  localparam int unsigned FB_ROM = 3;
  localparam int unsigned FB_ABOVE = 1;
  localparam int unsigned FB_BELOW = 0;
  localparam int unsigned PB_PUMP = 10;
  localparam int unsigned PB_SUPPLY = 9;
  localparam int unsigned PB_NVRAM = 8;
  localparam logic [15:0] SCALE_UNITY = 16'h4000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // Arbitrary neutral trace contents
  localparam logic [15:0] MAKER_WORD1 = 16'h0001;
  localparam logic [15:0] MAKER_WORD2 = 16'h0002;

  // ==========================================
  // Arithmetic constants
  localparam int unsigned SCALE_SHIFT = 14;
  localparam int unsigned FRAC_SHIFT = 15;
  localparam int unsigned MAG_SHIFT = 13;
  localparam logic [15:0] MAG_FACTOR = 16'h3333;
  localparam logic [4:0] ROOT_STEPS = 5'h10;
  localparam logic [31:0] ROOT_FIRST_BIT = 32'h4000_0000;
  localparam logic [31:0] MAG_MAX = 32'h0000_7fff;

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ROOT = 2'b01,
    ST_SCALE = 2'b10
  } fpd_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [15:0] wdata;
  } fpd_reg_req_t;

  typedef struct packed {
    logic adc1_clip;
    logic adc2_clip;
    logic dsp_fail;
    logic eeprom_fail;
    logic rom_parity_fail;
    logic pump_low;
    logic supply_low;
    logic nvram_fail;
  } fpd_events_t;

endpackage : fpd_pkg

//--- logic/fpd_diag_calib.sv
`timescale 1ns/100ps
module fpd_diag_calib (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire fpd_pkg::fpd_reg_req_t reg_req_i,
  input wire fpd_pkg::fpd_events_t events_i,
  input wire logic diag_latch_i,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] channel_one_i,
  input wire logic signed [15:0] channel_two_i,
  input wire logic [15:0] temperature_i,
  input wire logic [15:0] dac_code_i,
  input wire logic [15:0] clamp_high_i,
  input wire logic [15:0] clamp_low_i,
  input wire logic signed [15:0] field_upper_threshold_i,
  input wire logic signed [15:0] field_lower_threshold_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic signed [15:0] corrected_channel_one_o,
  output logic signed [15:0] corrected_channel_two_o,
  output logic [15:0] field_magnitude_o,
  output logic magnitude_valid_o,
  output logic field_range_alarm_o
);
  import fpd_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic signed [39:0] mul_shift(input logic signed [39:0] a, input logic signed [15:0] b,
                                                   input int unsigned sh);
    logic signed [55:0] p;
    p = a * b;
    return 40'(p >>> sh);
  endfunction : mul_shift

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767) begin
      return 16'sh7fff;
    end
    if (v < -40'sd32768) begin
      return 16'sh8000;
    end
    return v[15:0];
  endfunction : sat16

  function automatic logic signed [15:0] deadband(input logic signed [15:0] held, input logic signed [15:0] fresh,
                                                  input logic signed [15:0] setting);
    logic signed [16:0] diff;
    logic [16:0] width;
    diff = 17'(fresh) - 17'(held);
    width = 17'(-17'(setting));
    if (setting >= 0) begin
      return fresh;
    end
    if (diff < 0) begin
      diff = -diff;
    end
    return (17'(diff) > width) ? fresh : held;
  endfunction : deadband

  // ==========================================
  // Register file
  logic [15:0] user1_q, user2_q, phase_q, scale1_q, scale2_q;
  logic [15:0] coeff1_q, coeff2_q, coeff3_q, sel1_q, sel2_q, deadband_q;
  logic [15:0] fault_q, prog_q;
  logic wr_sel;

  assign wr_sel = reg_req_i.wr;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      user1_q <= ZERO_WORD;
      user2_q <= ZERO_WORD;
      phase_q <= ZERO_WORD;
      scale1_q <= SCALE_UNITY;
      scale2_q <= SCALE_UNITY;
      coeff1_q <= ZERO_WORD;
      coeff2_q <= ZERO_WORD;
      coeff3_q <= ZERO_WORD;
      sel1_q <= ZERO_WORD;
      sel2_q <= ZERO_WORD;
      deadband_q <= ZERO_WORD;
    end else if (wr_sel) begin
      unique case (reg_req_i.idx)
        IDX_USER1: user1_q <= reg_req_i.wdata;
        IDX_USER2: user2_q <= reg_req_i.wdata;
        IDX_PHASE: phase_q <= reg_req_i.wdata;
        IDX_SCALE1: scale1_q <= reg_req_i.wdata;
        IDX_SCALE2: scale2_q <= reg_req_i.wdata;
        IDX_COEFF1: coeff1_q <= reg_req_i.wdata;
        IDX_COEFF2: coeff2_q <= reg_req_i.wdata;
        IDX_COEFF3: coeff3_q <= reg_req_i.wdata;
        IDX_SEL1: sel1_q <= reg_req_i.wdata;
        IDX_SEL2: sel2_q <= reg_req_i.wdata;
        IDX_DEADBAND: deadband_q <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  // Read port: data one cycle after the request
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= ZERO_WORD;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.idx)
          IDX_FAULT: rd_data_o <= fault_q & FAULT_USED_MASK;
          IDX_PROG: rd_data_o <= prog_q & (PROG_HW_MASK | PROG_SW_MASK);
          IDX_MAKER1: rd_data_o <= MAKER_WORD1;
          IDX_MAKER2: rd_data_o <= MAKER_WORD2;
          IDX_USER1: rd_data_o <= user1_q;
          IDX_USER2: rd_data_o <= user2_q;
          IDX_PHASE: rd_data_o <= phase_q;
          IDX_SCALE1: rd_data_o <= scale1_q;
          IDX_SCALE2: rd_data_o <= scale2_q;
          IDX_COEFF1: rd_data_o <= coeff1_q;
          IDX_COEFF2: rd_data_o <= coeff2_q;
          IDX_COEFF3: rd_data_o <= coeff3_q;
          IDX_SEL1: rd_data_o <= sel1_q;
          IDX_SEL2: rd_data_o <= sel2_q;
          IDX_DEADBAND: rd_data_o <= deadband_q;
          default: rd_data_o <= ZERO_WORD;
        endcase
      end
    end
  end

  // ==========================================
  // Channel correction, first stage
  logic signed [39:0] ch1_w, ch2_w, temp_w, ph_term, g1, g2, poly, off1, off2;
  logic signed [15:0] stage1_ch1_q, stage1_ch2_q;
  logic stage1_valid_q;

  always_comb begin
    ch1_w = 40'(channel_one_i);
    ch2_w = 40'(channel_two_i);
    temp_w = 40'(signed'({1'b0, temperature_i[14:0]}));
    ph_term = mul_shift(ch1_w, phase_q, FRAC_SHIFT);
    g1 = mul_shift(ch1_w, scale1_q, SCALE_SHIFT);
    g2 = mul_shift(ch2_w + ph_term, scale2_q, SCALE_SHIFT);
    poly = 40'(signed'(coeff1_q)) + mul_shift(temp_w, coeff2_q, FRAC_SHIFT)
           + mul_shift(mul_shift(temp_w, coeff3_q, FRAC_SHIFT), temp_w[15:0], FRAC_SHIFT);
    off1 = mul_shift(poly, sel1_q, FRAC_SHIFT);
    off2 = mul_shift(poly, sel2_q, FRAC_SHIFT);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage1_ch1_q <= 16'sh0000;
      stage1_ch2_q <= 16'sh0000;
      stage1_valid_q <= 1'b0;
    end else begin
      stage1_valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        stage1_ch1_q <= sat16(g1 + off1);
        stage1_ch2_q <= sat16(g2 + off2);
      end
    end
  end

  // ==========================================
  // Deadband on both channels
  logic start_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      corrected_channel_one_o <= 16'sh0000;
      corrected_channel_two_o <= 16'sh0000;
      start_q <= 1'b0;
    end else begin
      start_q <= stage1_valid_q;
      if (stage1_valid_q) begin
        corrected_channel_one_o <= deadband(corrected_channel_one_o, stage1_ch1_q, deadband_q);
        corrected_channel_two_o <= deadband(corrected_channel_two_o, stage1_ch2_q, deadband_q);
      end
    end
  end

  // ==========================================
  // Magnitude: bit-serial square root, then 1.6 scale
  fpd_state_t state_q;
  logic [31:0] rem_q, root_q, bit_q, sum_sq, mag_prod;
  logic [32:0] trial;
  logic [4:0] step_q;
  logic signed [31:0] sq1, sq2;

  assign sq1 = corrected_channel_one_o * corrected_channel_one_o;
  assign sq2 = corrected_channel_two_o * corrected_channel_two_o;
  assign sum_sq = unsigned'(sq1) + unsigned'(sq2);
  assign trial = 33'(root_q) + 33'(bit_q);
  assign mag_prod = 32'(root_q[15:0] * MAG_FACTOR) >> MAG_SHIFT;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      rem_q <= 32'h0000_0000;
      root_q <= 32'h0000_0000;
      bit_q <= 32'h0000_0000;
      step_q <= 5'h00;
      field_magnitude_o <= ZERO_WORD;
      magnitude_valid_o <= 1'b0;
    end else begin
      magnitude_valid_o <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            rem_q <= sum_sq;
            root_q <= 32'h0000_0000;
            bit_q <= ROOT_FIRST_BIT;
            step_q <= ROOT_STEPS;
            state_q <= ST_ROOT;
          end
        end
        ST_ROOT: begin
          if (33'(rem_q) >= trial) begin
            rem_q <= rem_q - trial[31:0];
            root_q <= (root_q >> 1) + bit_q;
          end else begin
            root_q <= root_q >> 1;
          end
          bit_q <= bit_q >> 2;
          step_q <= step_q - 5'h01;
          if (step_q == 5'h01) begin
            state_q <= ST_SCALE;
          end
        end
        ST_SCALE: begin
          field_magnitude_o <= (mag_prod > MAG_MAX) ? MAG_MAX[15:0] : mag_prod[15:0];
          magnitude_valid_o <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Field window check and alarm
  logic above_q, below_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      above_q <= 1'b0;
      below_q <= 1'b0;
      field_range_alarm_o <= 1'b0;
    end else begin
      if (magnitude_valid_o) begin
        above_q <= signed'(field_magnitude_o) > field_upper_threshold_i;
        below_q <= signed'(field_magnitude_o) < field_lower_threshold_i;
      end
      field_range_alarm_o <= above_q | below_q;
    end
  end

  // ==========================================
  // Fault status word
  logic [15:0] fault_now;

  always_comb begin
    fault_now = ZERO_WORD;
    fault_now[FB_CLAMP_HI] = dac_code_i >= clamp_high_i;
    fault_now[FB_CLAMP_LO] = dac_code_i <= clamp_low_i;
    fault_now[FB_CLIP1] = events_i.adc1_clip;
    fault_now[FB_CLIP2] = events_i.adc2_clip;
    fault_now[FB_DSP] = events_i.dsp_fail;
    fault_now[FB_EEPROM] = events_i.eeprom_fail & diag_latch_i;
    fault_now[FB_ROM] = events_i.rom_parity_fail;
    fault_now[FB_ABOVE] = above_q;
    fault_now[FB_BELOW] = below_q;
  end

  // Latched mode keeps every flag until reset; otherwise live, except the EEPROM flag, which stays zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_q <= ZERO_WORD;
    end else if (diag_latch_i) begin
      fault_q <= (fault_q | fault_now) & FAULT_USED_MASK;
    end else begin
      fault_q <= fault_now & FAULT_USED_MASK;
    end
  end

  // ==========================================
  // Programming fault word: 10:8 write-one-to-clear, 5:0 plain
  logic [15:0] prog_set;

  always_comb begin
    prog_set = ZERO_WORD;
    prog_set[PB_PUMP] = events_i.pump_low;
    prog_set[PB_SUPPLY] = events_i.supply_low;
    prog_set[PB_NVRAM] = events_i.nvram_fail;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prog_q <= ZERO_WORD;
    end else if (wr_sel && reg_req_i.idx == IDX_PROG) begin
      prog_q <= (((prog_q & ~reg_req_i.wdata) & PROG_HW_MASK) | prog_set)
                | (reg_req_i.wdata & PROG_SW_MASK);
    end else begin
      prog_q <= (prog_q | prog_set) & (PROG_HW_MASK | PROG_SW_MASK);
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence seq_sample_in;
    sample_valid_i && state_q == ST_IDLE;
  endsequence

  sequence seq_quiet_step;
    stage1_valid_q && $signed(deadband_q) < 0
      && (17'(stage1_ch1_q) - 17'(corrected_channel_one_o)) <= -17'($signed(deadband_q))
      && (17'(corrected_channel_one_o) - 17'(stage1_ch1_q)) <= -17'($signed(deadband_q));
  endsequence

  a_mag_latency: assert property (seq_sample_in ##1 (!sample_valid_i)[*3] |-> ##[16:22] magnitude_valid_o)
    else $error("magnitude not produced in time");
  a_reserved_zero: assert property (fault_q[15:10] == 6'h00 && fault_q[2] == 1'b0 && prog_q[15:11] == 5'h00)
    else $error("reserved status bit set");
  a_clamp_high: assert property (!diag_latch_i && dac_code_i >= clamp_high_i |=> fault_q[FB_CLAMP_HI])
    else $error("upper clamp flag missing");
  a_clip_one: assert property (!diag_latch_i && events_i.adc1_clip |=> fault_q[FB_CLIP1])
    else $error("channel one clip flag missing");
  a_dsp_check: assert property (events_i.dsp_fail |=> fault_q[FB_DSP])
    else $error("processor check flag missing");
  a_eeprom_gate: assert property (!diag_latch_i |=> !fault_q[FB_EEPROM])
    else $error("memory flag shown without latching");
  a_rom_parity: assert property (events_i.rom_parity_fail |=> fault_q[FB_ROM])
    else $error("parity flag missing");
  a_field_above: assert property (magnitude_valid_o && signed'(field_magnitude_o) > field_upper_threshold_i
                                  |=> above_q ##1 field_range_alarm_o)
    else $error("upper field flag or alarm missing");
  a_pump_set_wins: assert property (events_i.pump_low |=> prog_q[PB_PUMP])
    else $error("pump flag lost");
  a_nvram_hold: assert property (prog_q[PB_NVRAM] && !(wr_sel && reg_req_i.idx == IDX_PROG) |=> prog_q[PB_NVRAM])
    else $error("write failure flag dropped");
  a_maker_ro: assert property (reg_req_i.rd && reg_req_i.idx == IDX_MAKER1 |=> rd_valid_o && rd_data_o == MAKER_WORD1)
    else $error("maker word wrong");
  a_deadband_hold: assert property (seq_quiet_step |=> $stable(corrected_channel_one_o))
    else $error("deadband let small change through");

endmodule : fpd_diag_calib

//--- bench/fpd_prog_model.sv
`timescale 1ns/100ps
module fpd_prog_model
  import fpd_pkg::*;
(
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i,
  output fpd_pkg::fpd_reg_req_t req_o
);
  // ==========================================
  // End-of-line programmer, register side
  initial req_o = '0;

  // Released fields scrambled, never left at the last value
  task automatic release_bus;
    req_o.wr = 1'b0;
    req_o.rd = 1'b0;
    req_o.idx = ~req_o.idx;
    req_o.wdata = ~req_o.wdata;
  endtask : release_bus

  task automatic write_word(input logic [3:0] idx, input logic [15:0] data);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: data};
    @(negedge clk_i);
    release_bus();
  endtask : write_word

  // Answer awaited for a bounded time, unknown if absent
  task automatic read_word(input logic [3:0] idx, output logic [15:0] data);
    data = 16'hxxxx;
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: req_o.wdata};
    @(negedge clk_i);
    release_bus();
    for (int n = 0; n < 4; n++) begin
      if (rd_valid_i === 1'b1) begin
        data = rd_data_i;
        break;
      end
      @(negedge clk_i);
    end
  endtask : read_word

  // Width stored as its negative
  task automatic set_deadband(input logic [15:0] width);
    write_word(IDX_DEADBAND, 16'h0000 - width);
  endtask : set_deadband
endmodule : fpd_prog_model

//--- bench/fpd_diag_calib_bench.sv
`timescale 1ns/100ps
module fpd_diag_calib_bench;
  import fpd_pkg::*;
  logic clk_i, reset_i, diag_latch, sample_valid, rd_valid, mag_valid, alarm;
  fpd_reg_req_t reg_req;
  fpd_events_t ev;
  logic signed [15:0] ch1, ch2, up_thr, lo_thr, cor1, cor2;
  logic [15:0] temp, dac, clamp_hi, clamp_lo, rd_data, fmag;
  int error_cnt, n_compared, cycles;

  fpd_diag_calib u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req), .events_i(ev),
    .diag_latch_i(diag_latch), .sample_valid_i(sample_valid), .channel_one_i(ch1), .channel_two_i(ch2),
    .temperature_i(temp), .dac_code_i(dac), .clamp_high_i(clamp_hi), .clamp_low_i(clamp_lo),
    .field_upper_threshold_i(up_thr), .field_lower_threshold_i(lo_thr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .corrected_channel_one_o(cor1), .corrected_channel_two_o(cor2),
    .field_magnitude_o(fmag), .magnitude_valid_o(mag_valid), .field_range_alarm_o(alarm));

  fpd_prog_model u_prog (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .req_o(reg_req));

  // ==========================================
  // Clock, timeout and reporting
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] run_length expected 19999 seen 20000");
      close_out();
    end
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_near(input string name, input int exp, input logic signed [15:0] got, input int tol);
    n_compared++;
    if ((got >= exp - tol && got <= exp + tol) !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_near

  // ==========================================
  // Helpers
  function automatic logic [15:0] reset_word(input int i);
    return (i == 7 || i == 8) ? SCALE_UNITY : (i == 2) ? MAKER_WORD1 : (i == 3) ? MAKER_WORD2 : ZERO_WORD;
  endfunction : reset_word

  task automatic rd_chk(input logic [3:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    u_prog.read_word(idx, d);
    check_word($sformatf("reg_%0d", idx), exp, d);
  endtask : rd_chk

  task automatic do_reset;
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
  endtask : do_reset

  task automatic pulse_event(input int k);
    @(negedge clk_i);
    ev[k] = 1'b1;
    @(negedge clk_i);
    ev = '0;
    repeat (2) @(negedge clk_i);
  endtask : pulse_event

  // Sample, then wait for the magnitude and the window flags
  task automatic send(input logic signed [15:0] a, input logic signed [15:0] b);
    int n;
    n = 0;
    @(negedge clk_i);
    ch1 = a;
    ch2 = b;
    sample_valid = 1'b1;
    @(negedge clk_i);
    sample_valid = 1'b0;
    while (mag_valid !== 1'b1 && n < 30) begin
      @(negedge clk_i);
      n++;
    end
    check_word("magnitude_valid", 16'h0001, {15'h0000, mag_valid});
    repeat (4) @(negedge clk_i);
  endtask : send

  // ==========================================
  // Scenarios
  task automatic sc_reset_and_access;
    logic [3:0] ro_idx [4];
    ro_idx = '{4'h0, 4'h2, 4'h3, 4'hf};
    for (int i = 0; i < 16; i++) rd_chk(4'(i), reset_word(i));
    for (int i = 4; i < 15; i++) u_prog.write_word(4'(i), 16'h8000 | 16'(i * 257));
    for (int i = 4; i < 15; i++) rd_chk(4'(i), 16'h8000 | 16'(i * 257));
    foreach (ro_idx[j]) u_prog.write_word(ro_idx[j], 16'hffff);
    rd_chk(IDX_FAULT, ZERO_WORD);
    rd_chk(IDX_MAKER1, MAKER_WORD1);
    rd_chk(IDX_MAKER2, MAKER_WORD2);
    rd_chk(4'hf, ZERO_WORD);
  endtask : sc_reset_and_access

  task automatic sc_fault_events;
    diag_latch = 1'b1;
    for (int k = 7; k >= 3; k--) begin
      do_reset();
      pulse_event(k);
      rd_chk(IDX_FAULT, 16'(1 << k));
    end
    diag_latch = 1'b0;
    do_reset();
    ev.adc1_clip = 1'b1;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0080);
    ev = '0;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0000);
    pulse_event(4);
    rd_chk(IDX_FAULT, 16'h0000);
  endtask : sc_fault_events

  task automatic sc_prog_status;
    logic [15:0] e;
    e = 16'h0000;
    do_reset();
    for (int k = 2; k >= 0; k--) begin
      pulse_event(k);
      e = e | 16'(1 << (k + 8));
      rd_chk(IDX_PROG, e);
    end
    u_prog.write_word(IDX_PROG, 16'hffff);
    rd_chk(IDX_PROG, 16'h003f);
    // Pump event and its clear in one cycle: set must win
    fork
      pulse_event(2);
      u_prog.write_word(IDX_PROG, 16'h0400);
    join
    rd_chk(IDX_PROG, 16'h0400);
  endtask : sc_prog_status

  task automatic sc_clamp;
    dac = clamp_hi;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0200);
    dac = clamp_lo;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0100);
    dac = 16'h4000;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0000);
    // Lower clamp at full scale raises the low flag
    clamp_lo = 16'h7fff;
    repeat (2) @(negedge clk_i);
    rd_chk(IDX_FAULT, 16'h0100);
    clamp_lo = 16'h1000;
  endtask : sc_clamp

  task automatic sc_magnitude_window;
    do_reset();
    send(16'sd3000, 16'sd4000);
    check_near("channel_one", 3000, cor1, 0);
    check_near("channel_two", 4000, cor2, 0);
    check_near("magnitude", 8000, fmag, 3);
    check_word("alarm", 16'h0000, {15'h0000, alarm});
    up_thr = 16'sd7000;
    send(16'sd3000, 16'sd4000);
    check_word("alarm", 16'h0001, {15'h0000, alarm});
    rd_chk(IDX_FAULT, 16'h0002);
    up_thr = 16'sh7fff;
    lo_thr = 16'sd9000;
    send(16'sd3000, 16'sd4000);
    check_word("alarm", 16'h0001, {15'h0000, alarm});
    rd_chk(IDX_FAULT, 16'h0001);
    lo_thr = 16'sh8000;
    send(16'sd3000, 16'sd4000);
    check_word("alarm", 16'h0000, {15'h0000, alarm});
  endtask : sc_magnitude_window

  task automatic sc_calibration;
    do_reset();
    u_prog.write_word(IDX_SCALE1, 16'h2000);
    send(16'sd3000, 16'sd4000);
    check_near("channel_one", 1500, cor1, 1);
    u_prog.write_word(IDX_SCALE1, SCALE_UNITY);
    u_prog.write_word(IDX_COEFF1, 16'h03e8);
    u_prog.write_word(IDX_SEL2, 16'h4000);
    send(16'sd3000, 16'sd4000);
    check_near("channel_one", 3000, cor1, 0);
    check_near("channel_two", 4500, cor2, 2);
    // Half-scale temperature: 1000 + 2048/2 + 4096/4, half of it added
    temp = 16'h4000;
    u_prog.write_word(IDX_COEFF2, 16'h0800);
    u_prog.write_word(IDX_COEFF3, 16'h1000);
    send(16'sd3000, 16'sd4000);
    check_near("channel_two", 5524, cor2, 2);
    // Thirty degree skew: sine at half scale, channel two gain 16384/cos
    u_prog.write_word(IDX_SEL2, ZERO_WORD);
    u_prog.write_word(IDX_PHASE, 16'h4000);
    u_prog.write_word(IDX_SCALE2, 16'h49e7);
    send(16'sd3000, 16'sd4000);
    check_near("channel_one", 3000, cor1, 0);
    check_near("channel_two", 6351, cor2, 2);
    temp = 16'h0000;
  endtask : sc_calibration

  task automatic sc_deadband;
    do_reset();
    u_prog.set_deadband(16'h0064);
    rd_chk(IDX_DEADBAND, 16'hff9c);
    send(16'sd3000, 16'sd4000);
    check_near("channel_one", 3000, cor1, 0);
    send(16'sd3050, 16'sd4050);
    check_near("channel_one", 3000, cor1, 0);
    check_near("channel_two", 4000, cor2, 0);
    send(16'sd3200, 16'sd4000);
    check_near("channel_one", 3200, cor1, 0);
  endtask : sc_deadband

  // ==========================================
  // Main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    reset_i = 1'b1;
    diag_latch = 1'b0;
    sample_valid = 1'b0;
    ev = '0;
    ch1 = 16'sd0;
    ch2 = 16'sd0;
    temp = 16'h0000;
    dac = 16'h4000;
    clamp_hi = 16'h7000;
    clamp_lo = 16'h1000;
    up_thr = 16'sh7fff;
    lo_thr = 16'sh8000;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    sc_reset_and_access();
    sc_fault_events();
    sc_prog_status();
    sc_clamp();
    sc_magnitude_window();
    sc_calibration();
    sc_deadband();
    close_out();
  end
endmodule : fpd_diag_calib_bench
